// ==== core/ood_pkg.sv ====
// Package of constants for the internal oscillator divider block
package ood_pkg;
    // ****************************************
    // Timing and divider constants
    // ****************************************
    localparam int OSC_FREQ_KHZ = 5000;
    localparam int CORE_FREQ_KHZ = 50000;
    localparam int OSC_EN_DIV = CORE_FREQ_KHZ / OSC_FREQ_KHZ;
    localparam int DIV_RATIO_DEFAULT = 128;
    localparam int DIV_RATIO_MID = 1024;
    localparam int DIV_RATIO_MAX = 1048576;
    localparam int FEEDBACK_MC_INDEX = 15;
    localparam logic OSC_ENABLE_RESET = 1'b0;
endpackage

// ==== core/ood_route_if.sv ====
// Interface carrying oscillator outputs to the routing multiplexers
`timescale 1ns/10ps
interface ood_route_if;
    logic osc_clk;
    logic div_clk;
    modport source (output osc_clk, output div_clk);
    modport sink (input osc_clk, input div_clk);
endinterface

// ==== core/ood_route_mux.sv ====
// Macrocell feedback multiplexers onto the global routing pool
`timescale 1ns/10ps
module ood_route_mux
    import ood_pkg::*;
(
    // Clock sources
    ood_route_if.sink src,
    // Macrocell feedback
    input wire logic osc_mc_feedback,
    input wire logic timer_mc_feedback,
    input wire logic osc_mc_select,
    input wire logic timer_mc_select,
    // Global routing pool
    output logic osc_pool_line,
    output logic timer_pool_line
);
    // ****************************************
    // Feedback selection
    // ****************************************
    assign osc_pool_line = osc_mc_select ? src.osc_clk : osc_mc_feedback;
    assign timer_pool_line = timer_mc_select ? src.div_clk : timer_mc_feedback;
endmodule

// ==== core/ood_osc_divider.sv ====
// Internal oscillator with power-of-two divider
`timescale 1ns/10ps
module ood_osc_divider
    import ood_pkg::*;
#(
    parameter int DIV_RATIO = DIV_RATIO_DEFAULT
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic osc_used,
    // Fabric controls
    input wire logic divider_reset_in,
    input wire logic osc_disable_in,
    // Macrocell feedback
    input wire logic osc_mc_feedback,
    input wire logic timer_mc_feedback,
    // Clock outputs
    output logic osc_clock_out,
    output logic divided_clock_out,
    output logic osc_running,
    // Global routing pool
    output logic osc_pool_line,
    output logic timer_pool_line
);
    localparam int NBITS = $clog2(DIV_RATIO);
    localparam int HALF = OSC_EN_DIV / 2;

    if (DIV_RATIO != DIV_RATIO_DEFAULT && DIV_RATIO != DIV_RATIO_MID &&
        DIV_RATIO != DIV_RATIO_MAX) begin : g_bad_ratio
        $error("Divide ratio must be 128, 1024 or 1048576");
    end

    // ****************************************
    // Reset and input synchronisers
    // ****************************************
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    logic [1:0] dis_sync;
    logic [1:0] dres_sync;
    logic [1:0] used_sync;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dis_sync <= 2'h0;
            dres_sync <= 2'h0;
            used_sync <= 2'h0;
        end else begin
            dis_sync <= {dis_sync[0], osc_disable_in};
            dres_sync <= {dres_sync[0], divider_reset_in};
            used_sync <= {used_sync[0], osc_used};
        end
    end

    // ****************************************
    // Oscillator model
    // ****************************************
    logic enabled;
    assign enabled = used_sync[1] && !dis_sync[1];
    assign osc_running = enabled;

    logic [$clog2(OSC_EN_DIV)-1:0] phase;
    logic osc_level;
    logic osc_tick;
    assign osc_tick = enabled && (phase == ($bits(phase))'(OSC_EN_DIV - 1));
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase <= '0;
        end else if (!enabled || osc_tick) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_level <= OSC_ENABLE_RESET;
        end else if (!enabled) begin
            osc_level <= 1'b0;
        end else begin
            osc_level <= (phase < ($bits(phase))'(HALF - 1)) || osc_tick;
        end
    end

    // ****************************************
    // Divider reset stage and counter
    // ****************************************
    logic div_clear_q;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_clear_q <= 1'b1;
        end else if (!enabled) begin
            div_clear_q <= 1'b1;
        end else if (osc_tick) begin
            div_clear_q <= dres_sync[1];
        end
    end

    logic [NBITS-1:0] count;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count <= '0;
        end else if (!enabled) begin
            count <= '0;
        end else if (osc_tick) begin
            count <= div_clear_q ? '0 : count + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_clock_out <= 1'b0;
            divided_clock_out <= 1'b0;
        end else begin
            osc_clock_out <= enabled && osc_level;
            divided_clock_out <= enabled && count[NBITS-1];
        end
    end

    // ****************************************
    // Routing to fabric
    // ****************************************
    ood_route_if route ();
    assign route.osc_clk = osc_clock_out;
    assign route.div_clk = divided_clock_out;
    ood_route_mux u_mux (
        .src(route),
        .osc_mc_feedback(osc_mc_feedback),
        .timer_mc_feedback(timer_mc_feedback),
        .osc_mc_select(enabled),
        .timer_mc_select(enabled),
        .osc_pool_line(osc_pool_line),
        .timer_pool_line(timer_pool_line)
    );

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_off;
        !enabled;
    endsequence

    sequence s_quiet;
        (!osc_tick) [*8] ##1 !osc_tick;
    endsequence

    sequence s_next_tick;
        osc_tick || !enabled;
    endsequence

    property p_off_low;
        @(posedge core_clk) disable iff (!rst_sync_n)
        s_off ##1 s_off |-> !osc_clock_out && !divided_clock_out;
    endproperty
    AST_OFF_LOW: assert property (p_off_low)
        else $error("Clock outputs not low while disabled");

    property p_dis_stops;
        @(posedge core_clk) disable iff (!rst_sync_n)
        dis_sync[1] |=> count == '0 && div_clear_q && !osc_clock_out && !divided_clock_out;
    endproperty
    AST_DIS_STOPS: assert property (p_dis_stops)
        else $error("Disable did not stop oscillator");

    property p_default_off;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !used_sync[1] |=> !osc_level && !osc_clock_out;
    endproperty
    AST_DEFAULT_OFF: assert property (p_default_off)
        else $error("Oscillator ran without use");

    property p_period;
        @(posedge core_clk) disable iff (!rst_sync_n)
        osc_tick |=> s_quiet ##1 s_next_tick;
    endproperty
    AST_PERIOD: assert property (p_period)
        else $error("Oscillator period wrong");

    property p_clear;
        @(posedge core_clk) disable iff (!rst_sync_n)
        osc_tick && div_clear_q |=> count == '0;
    endproperty
    AST_CLEAR: assert property (p_clear)
        else $error("Divider not cleared");

    property p_reset_stage;
        @(posedge core_clk) disable iff (!rst_sync_n)
        osc_tick && dres_sync[1] |=> div_clear_q;
    endproperty
    AST_RESET_STAGE: assert property (p_reset_stage)
        else $error("Divider reset stage did not capture reset");

    property p_count;
        @(posedge core_clk) disable iff (!rst_sync_n)
        osc_tick && !div_clear_q && enabled |=> count == $past(count) + 1'b1;
    endproperty
    AST_COUNT: assert property (p_count)
        else $error("Divider did not advance");

    property p_route;
        @(posedge core_clk) disable iff (!rst_sync_n)
        enabled |-> timer_pool_line == divided_clock_out && osc_pool_line == osc_clock_out;
    endproperty
    AST_ROUTE: assert property (p_route)
        else $error("Routing mux wrong");

    property p_route_fb;
        @(posedge core_clk) disable iff (!rst_sync_n)
        s_off |-> osc_pool_line == osc_mc_feedback && timer_pool_line == timer_mc_feedback;
    endproperty
    AST_ROUTE_FB: assert property (p_route_fb)
        else $error("Routing mux did not pass macrocell feedback");

    property p_divout;
        @(posedge core_clk) disable iff (!rst_sync_n)
        enabled && $past(enabled) |-> divided_clock_out == $past(count[NBITS-1]);
    endproperty
    AST_DIVOUT: assert property (p_divout)
        else $error("Divided output does not follow counter");
endmodule

// ==== test/ood_fabric_model.sv ====
// Macrocell fabric model driving the block's optional controls
`timescale 1ns/10ps
module ood_fabric_model (
    // Clock
    input wire logic core_clk,
    // Bench requests
    input wire logic reset_req,
    input wire logic disable_req,
    // Macrocell outputs
    output logic divider_reset_in,
    output logic osc_disable_in,
    output logic osc_mc_feedback,
    output logic timer_mc_feedback
);
    // ****
    // Registered macrocell outputs
    // ****
    logic fb_toggle = 1'b0;
    logic fb_delayed = 1'b1;
    always @(posedge core_clk) begin
        divider_reset_in <= #1 reset_req;
        osc_disable_in <= #1 disable_req;
        fb_toggle <= #1 ~fb_toggle;
        fb_delayed <= #1 fb_toggle;
    end
    assign osc_mc_feedback = fb_toggle;
    assign timer_mc_feedback = fb_delayed;
endmodule

// ==== test/onchip_oscillator_divider_test.sv ====
// Testbench of the oscillator divider block
`timescale 1ns/10ps
module onchip_oscillator_divider_test;
    import ood_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_used = 1'b0;
    logic reset_req = 1'b0;
    logic disable_req = 1'b0;
    logic divider_reset_in, osc_disable_in, osc_mc_feedback, timer_mc_feedback;
    logic osc_clock_out, divided_clock_out, osc_running, osc_pool_line, timer_pool_line;
    int n_mismatch = 0;
    int num_checks = 0;
    int cnt;
    always #10 core_clk = ~core_clk;
    ood_fabric_model fab (.core_clk(core_clk), .reset_req(reset_req),
        .disable_req(disable_req), .divider_reset_in(divider_reset_in),
        .osc_disable_in(osc_disable_in), .osc_mc_feedback(osc_mc_feedback),
        .timer_mc_feedback(timer_mc_feedback));
    ood_osc_divider #(.DIV_RATIO(DIV_RATIO_DEFAULT)) uut (.core_clk(core_clk),
        .rst_n(rst_n), .osc_used(osc_used), .divider_reset_in(divider_reset_in),
        .osc_disable_in(osc_disable_in), .osc_mc_feedback(osc_mc_feedback),
        .timer_mc_feedback(timer_mc_feedback), .osc_clock_out(osc_clock_out),
        .divided_clock_out(divided_clock_out), .osc_running(osc_running),
        .osc_pool_line(osc_pool_line), .timer_pool_line(timer_pool_line));
    // ****
    // Tasks
    // ****
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Counts oscillator rises for n cycles, or until the divided clock rises
    task run(input bit to_div, input int n, output int rises);
        logic po, pd;
        rises = 0;
        for (int i = 0; i < n; i++) begin
            po = osc_clock_out;
            pd = divided_clock_out;
            tick(1);
            if (!po && osc_clock_out) rises++;
            if (to_div && !pd && divided_clock_out) return;
        end
        if (to_div) begin
            n_mismatch++;
            $display("ERROR divided rise expected seen none");
            finish_test();
        end
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        tick(20);
        rst_n = 1'b1;
        tick(4);
        run(0, 100, cnt);
        check("osc off rises", 0, cnt);
        check("running off", 0, osc_running);
        check("osc pool feedback", osc_mc_feedback, osc_pool_line);
        check("timer pool feedback", timer_mc_feedback, timer_pool_line);
        osc_used = 1'b1;
        tick(4);
        check("running enabled", 1, osc_running);
        run(0, 200, cnt);
        check("osc rises", 200 / OSC_EN_DIV, cnt);
        check("osc pool", osc_clock_out, osc_pool_line);
        run(1, 3000, cnt);
        run(1, 3000, cnt);
        check("div period", DIV_RATIO_DEFAULT, cnt);
        tick(600);
        check("div high", 1, divided_clock_out);
        check("timer pool", divided_clock_out, timer_pool_line);
        tick(80);
        check("div low", 0, divided_clock_out);
        tick(640);
        check("div high again", 1, divided_clock_out);
        reset_req = 1'b1;
        tick(40);
        check("div in reset", 0, divided_clock_out);
        reset_req = 1'b0;
        run(1, 3000, cnt);
        check("first rise late", 1, cnt >= 65 && cnt <= 67);
        disable_req = 1'b1;
        tick(8);
        check("running disabled", 0, osc_running);
        run(0, 200, cnt);
        check("disabled rises", 0, cnt);
        check("osc low", 0, osc_clock_out);
        check("div low disabled", 0, divided_clock_out);
        disable_req = 1'b0;
        tick(8);
        run(1, 3000, cnt);
        check("restart rise", 1, cnt >= 65 && cnt <= 67);
        finish_test();
    end
endmodule
